/* hw/inactivity_detect_map.svh */
// Register offsets, field positions and reset values of the stillness detector
`ifndef INACTIVITY_DETECT_MAP_SVH
`define INACTIVITY_DETECT_MAP_SVH

`define ADDR_STILL_THRESH_HIGH 8'h23
`define ADDR_STILL_THRESH_LOW 8'h24
`define ADDR_STILL_COUNT_HIGH 8'h25
`define ADDR_STILL_COUNT_LOW 8'h26
`define ADDR_MOTION_CTL 8'h27
`define ADDR_EVENT_STATUS 8'h30
`define ADDR_EVENT_MASK 8'h31

`define RESET_BYTE 8'h00
`define READ_UNMAPPED 8'h00

`define THRESH_HIGH_MSB 6
`define THRESH_LOW_MSB 7
`define THRESH_LOW_LSB 2
`define CTL_SEQ_MSB 5
`define CTL_SEQ_LSB 4
`define CTL_STILL_EN_BIT 2
`define CTL_MOTION_EN_BIT 0

`define EVT_MOTION_BIT 0
`define EVT_STILL_BIT 1
`define EVT_AUX_BIT 2
`define EVT_WIDTH 3

`endif

/* hw/inactivity_detect_pkg.sv */
// Types and shared magnitude function of the stillness detector
package inactivity_detect_pkg;

  typedef enum logic [1:0] {
    SEQ_SIMUL = 2'b00,
    SEQ_LINKED = 2'b01,
    SEQ_SIMUL_ALT = 2'b10,
    SEQ_LOOPED = 2'b11
  } seq_mode_t;

  typedef enum logic {
    ARM_STILL = 1'b0,
    ARM_MOTION = 1'b1
  } arm_t;

  // Magnitude of a signed sample; full negative scale gives 14'h2000 unsigned
  function automatic logic [13:0] sample_magnitude(input logic [13:0] s);
    sample_magnitude = s[13] ? 14'(~s + 14'h0001) : s;
  endfunction : sample_magnitude

endpackage : inactivity_detect_pkg

/* hw/axis_stillness_compare.sv */
// Three-axis magnitude comparison against the stillness threshold
`timescale 1ns/100ps
module axis_stillness_compare (
  // Samples
  input wire logic [13:0] sample_x,
  input wire logic [13:0] sample_y,
  input wire logic [13:0] sample_z,
  // Threshold
  input wire logic [12:0] stillness_threshold,
  // Result
  output logic all_below
);

  logic [13:0] limit;

  assign limit = {1'b0, stillness_threshold};

  // Strictly below on every axis; equal counts as movement
  always_comb begin
    all_below = (inactivity_detect_pkg::sample_magnitude(sample_x) < limit) &&
                (inactivity_detect_pkg::sample_magnitude(sample_y) < limit) &&
                (inactivity_detect_pkg::sample_magnitude(sample_z) < limit);
  end

endmodule : axis_stillness_compare

/* hw/inactivity_detect_control.sv */
// Stillness detection, detector sequencing and its register file
// Notes on behaviour
// - Stillness judged by each signed sample magnitude against an unsigned 13-bit threshold.
// - Low threshold register holds threshold bits 5..0 at 7..2; bits 1..0 read zero.
// - High threshold register gives bits 12..6, placed above the low part.
// - Stillness event after the programmed 16-bit count of consecutive all-below samples.
// - Count register 0x25 holds bits 15..8, 0x26 bits 7..0; both reset zero.
// - Sequencing 00: both detectors run, no autosleep, host acknowledges by status read.
// - Sequencing 10 behaves exactly like 00.
// - Sequencing 01: detectors alternate, one armed; host still acknowledges by status read.
// - Auxiliary channel motion only in simultaneous modes; linking affects the axes only.
// - Control register resets zero, bits 7..6 read zero, sequencing at 5..4.
// - Sequencing 11: detectors alternate and acknowledge their events internally.
// - Linked or looped only with both enables set, else simultaneous.
`timescale 1ns/100ps
`include "inactivity_detect_map.svh"
module inactivity_detect_control (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Acceleration samples
  input wire logic sample_valid,
  input wire logic [13:0] sample_x,
  input wire logic [13:0] sample_y,
  input wire logic [13:0] sample_z,
  // Motion detector outside this block
  input wire logic motion_event,
  input wire logic aux_motion_event,
  output logic motion_armed,
  output logic aux_motion_armed,
  // Stillness results
  output logic stillness_armed,
  output logic stillness_event,
  // Interrupt
  output logic irq
);

  logic [6:0] thresh_high;
  logic [5:0] thresh_low;
  logic [7:0] count_high;
  logic [7:0] count_low;
  logic [5:0] ctl;
  logic [`EVT_WIDTH-1:0] status;
  logic [`EVT_WIDTH-1:0] mask;

  logic [12:0] stillness_threshold;
  logic [15:0] stillness_sample_count;
  logic [15:0] target_eff;
  logic [15:0] still_count;
  logic still_reported;
  logic all_below;
  logic still_hit;
  logic motion_taken;
  logic aux_taken;
  logic motion_detector_enable;
  logic stillness_detector_enable;
  logic both_en;
  logic alternating;
  logic self_ack;
  inactivity_detect_pkg::seq_mode_t detector_sequencing_select;
  inactivity_detect_pkg::arm_t arm;
  logic [`EVT_WIDTH-1:0] evt;
  logic [`EVT_WIDTH-1:0] evt_clear;
  logic [`EVT_WIDTH-1:0] next_status;

  function automatic logic hit(input logic strobe, input logic [7:0] addr, input logic [7:0] target);
    hit = strobe && (addr == target);
  endfunction : hit

  // Register writes

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      thresh_high <= 7'h00;
      thresh_low <= 6'h00;
    end else if (clk_en) begin
      if (hit(reg_wr, reg_addr, `ADDR_STILL_THRESH_HIGH)) begin
        thresh_high <= reg_wdata[`THRESH_HIGH_MSB:0];
      end
      if (hit(reg_wr, reg_addr, `ADDR_STILL_THRESH_LOW)) begin
        thresh_low <= reg_wdata[`THRESH_LOW_MSB:`THRESH_LOW_LSB];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_high <= `RESET_BYTE;
      count_low <= `RESET_BYTE;
    end else if (clk_en) begin
      if (hit(reg_wr, reg_addr, `ADDR_STILL_COUNT_HIGH)) begin
        count_high <= reg_wdata;
      end
      if (hit(reg_wr, reg_addr, `ADDR_STILL_COUNT_LOW)) begin
        count_low <= reg_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl <= 6'h00;
      mask <= 3'h0;
    end else if (clk_en) begin
      if (hit(reg_wr, reg_addr, `ADDR_MOTION_CTL)) begin
        ctl <= reg_wdata[`CTL_SEQ_MSB:0];
      end
      if (hit(reg_wr, reg_addr, `ADDR_EVENT_MASK)) begin
        mask <= reg_wdata[`EVT_WIDTH-1:0];
      end
    end
  end

  assign stillness_threshold = {thresh_high, thresh_low};
  assign stillness_sample_count = {count_high, count_low};
  // A zero count would never be reached; treat it as one sample
  assign target_eff = (stillness_sample_count == 16'h0000) ? 16'h0001 : stillness_sample_count;

  // Sequencing decode

  assign motion_detector_enable = ctl[`CTL_MOTION_EN_BIT];
  assign stillness_detector_enable = ctl[`CTL_STILL_EN_BIT];
  assign both_en = motion_detector_enable && stillness_detector_enable;
  assign detector_sequencing_select = inactivity_detect_pkg::seq_mode_t'(ctl[`CTL_SEQ_MSB:`CTL_SEQ_LSB]);

  always_comb begin
    alternating = 1'b0;
    self_ack = 1'b0;
    unique case (detector_sequencing_select)
      inactivity_detect_pkg::SEQ_SIMUL, inactivity_detect_pkg::SEQ_SIMUL_ALT: begin
        alternating = 1'b0;
      end
      inactivity_detect_pkg::SEQ_LINKED: begin
        alternating = both_en;
      end
      inactivity_detect_pkg::SEQ_LOOPED: begin
        alternating = both_en;
        self_ack = both_en;
      end
    endcase
  end

  assign stillness_armed = stillness_detector_enable &&
                           (!alternating || (arm == inactivity_detect_pkg::ARM_STILL));
  assign motion_armed = motion_detector_enable &&
                        (!alternating || (arm == inactivity_detect_pkg::ARM_MOTION));
  // Auxiliary channels never follow the linking
  assign aux_motion_armed = motion_detector_enable && !alternating;

  assign motion_taken = motion_armed && motion_event;
  assign aux_taken = aux_motion_armed && aux_motion_event;

  // Alternation starts by watching for stillness
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      arm <= inactivity_detect_pkg::ARM_STILL;
    end else if (clk_en) begin
      if (!alternating) begin
        arm <= inactivity_detect_pkg::ARM_STILL;
      end else if (still_hit) begin
        arm <= inactivity_detect_pkg::ARM_MOTION;
      end else if (motion_taken) begin
        arm <= inactivity_detect_pkg::ARM_STILL;
      end
    end
  end

  // Stillness counter

  axis_stillness_compare compare (
    .sample_x(sample_x),
    .sample_y(sample_y),
    .sample_z(sample_z),
    .stillness_threshold(stillness_threshold),
    .all_below(all_below)
  );

  assign still_hit = stillness_armed && sample_valid && all_below && !still_reported &&
                     ((still_count + 16'h0001) == target_eff);

  // One event per still period; it re-arms after movement or while stillness is disarmed
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      still_count <= 16'h0000;
      still_reported <= 1'b0;
    end else if (clk_en) begin
      if (!stillness_armed) begin
        still_count <= 16'h0000;
        still_reported <= 1'b0;
      end else if (sample_valid) begin
        if (!all_below) begin
          still_count <= 16'h0000;
          still_reported <= 1'b0;
        end else if (!still_reported) begin
          still_count <= still_count + 16'h0001;
          still_reported <= still_hit;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stillness_event <= 1'b0;
    end else if (clk_en) begin
      stillness_event <= still_hit;
    end
  end

  // Event status and interrupt

  assign evt = {aux_taken, still_hit, motion_taken};

  always_comb begin
    evt_clear = 3'h0;
    if (hit(reg_wr, reg_addr, `ADDR_EVENT_STATUS)) begin
      evt_clear = evt_clear | reg_wdata[`EVT_WIDTH-1:0];
    end
    if (hit(reg_rd, reg_addr, `ADDR_EVENT_STATUS)) begin
      evt_clear = 3'h7;
    end
    // Looped mode: the opposite detector firing acknowledges the other
    if (self_ack && still_hit) begin
      evt_clear[`EVT_MOTION_BIT] = 1'b1;
    end
    if (self_ack && motion_taken) begin
      evt_clear[`EVT_STILL_BIT] = 1'b1;
    end
    // New events win over any clear in the same cycle
    next_status = (status & ~evt_clear) | evt;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status <= 3'h0;
    end else if (clk_en) begin
      status <= next_status;
    end
  end

  assign irq = |(status & mask);

  // Read port, data one cycle after the strobe

  function automatic logic [7:0] read_value(input logic [7:0] addr);
    unique case (addr)
      `ADDR_STILL_THRESH_HIGH: read_value = {1'b0, thresh_high};
      `ADDR_STILL_THRESH_LOW: read_value = {thresh_low, 2'b00};
      `ADDR_STILL_COUNT_HIGH: read_value = count_high;
      `ADDR_STILL_COUNT_LOW: read_value = count_low;
      `ADDR_MOTION_CTL: read_value = {2'b00, ctl};
      `ADDR_EVENT_STATUS: read_value = {5'h00, status};
      `ADDR_EVENT_MASK: read_value = {5'h00, mask};
      default: read_value = `READ_UNMAPPED;
    endcase
  endfunction : read_value

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? read_value(reg_addr) : 8'h00;
    end
  end

  // Checks

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_read_of(logic [7:0] a);
    clk_en && reg_rd && (reg_addr == a);
  endsequence

  sequence s_count_high_write;
    clk_en && reg_wr && (reg_addr == `ADDR_STILL_COUNT_HIGH);
  endsequence

  property p_low_reserved;
    s_read_of(`ADDR_STILL_THRESH_LOW) |=> (reg_rdata[1:0] == 2'b00);
  endproperty
  a_low_reserved: assert property (p_low_reserved) else $error("low threshold reserved bits not zero");

  property p_ctl_reserved;
    s_read_of(`ADDR_MOTION_CTL) |=> (reg_rdata[7:6] == 2'b00);
  endproperty
  a_ctl_reserved: assert property (p_ctl_reserved) else $error("control reserved bits not zero");

  property p_count_readback;
    s_count_high_write ##1 s_read_of(`ADDR_STILL_COUNT_HIGH) |=> (reg_rdata == $past(reg_wdata, 2));
  endproperty
  a_count_readback: assert property (p_count_readback) else $error("count high readback wrong");

  property p_event_below;
    stillness_event |->
      (inactivity_detect_pkg::sample_magnitude($past(sample_x)) < {1'b0, $past(thresh_high), $past(thresh_low)}) &&
      (inactivity_detect_pkg::sample_magnitude($past(sample_y)) < {1'b0, $past(thresh_high), $past(thresh_low)}) &&
      (inactivity_detect_pkg::sample_magnitude($past(sample_z)) < {1'b0, $past(thresh_high), $past(thresh_low)});
  endproperty
  a_event_below: assert property (p_event_below) else $error("stillness event with axis above threshold");

  property p_event_count;
    stillness_event |-> ($past(still_count) == ($past(target_eff) - 16'h0001));
  endproperty
  a_event_count: assert property (p_event_count) else $error("stillness event at wrong count");

  property p_restart;
    clk_en && stillness_armed && sample_valid && !all_below |=> (still_count == 16'h0000);
  endproperty
  a_restart: assert property (p_restart) else $error("count not restarted on movement");

  property p_simul_both;
    both_en && !ctl[`CTL_SEQ_LSB] |-> (motion_armed && stillness_armed && aux_motion_armed);
  endproperty
  a_simul_both: assert property (p_simul_both) else $error("simultaneous mode left a detector idle");

  property p_one_armed;
    both_en && ctl[`CTL_SEQ_LSB] |-> (motion_armed != stillness_armed) && !aux_motion_armed;
  endproperty
  a_one_armed: assert property (p_one_armed) else $error("alternating mode armed both detectors");

  property p_fallback;
    !both_en && stillness_detector_enable |-> stillness_armed;
  endproperty
  a_fallback: assert property (p_fallback) else $error("fallback mode disarmed stillness");

  property p_loop_ack;
    clk_en && self_ack && still_hit |=> !status[`EVT_MOTION_BIT] && status[`EVT_STILL_BIT];
  endproperty
  a_loop_ack: assert property (p_loop_ack) else $error("looped mode kept old motion event");

  property p_host_ack;
    s_read_of(`ADDR_EVENT_STATUS) ##0 (evt == 3'h0) |=> (status == 3'h0) && !irq;
  endproperty
  a_host_ack: assert property (p_host_ack) else $error("status read did not acknowledge");

endmodule : inactivity_detect_control

/* tb/host_model.sv */
// Host microcontroller model that drives the register port
`timescale 1ns/100ps
module host_model (
  // Clock
  input wire logic sys_clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Write then read with no idle cycle between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
  endtask : wr_rd

  // Status reads double as the interrupt acknowledge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : host_model

/* tb/tb.sv */
// Self-checking bench for the stillness detector block
`timescale 1ns/100ps
module tb;
  logic sys_clk;
  logic rst;
  logic clk_en;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic sample_valid;
  logic [13:0] sample_x;
  logic [13:0] sample_y;
  logic [13:0] sample_z;
  logic motion_event;
  logic aux_motion_event;
  logic motion_armed;
  logic aux_motion_armed;
  logic stillness_armed;
  logic stillness_event;
  logic irq;
  int n_mismatch;
  int num_checks;

  host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  inactivity_detect_control dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z),
    .motion_event(motion_event), .aux_motion_event(aux_motion_event), .motion_armed(motion_armed),
    .aux_motion_armed(aux_motion_armed), .stillness_armed(stillness_armed),
    .stillness_event(stillness_event), .irq(irq));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask : rchk

  // One sample; the event pulse stands in the cycle after the taking edge
  task automatic smp(input logic [13:0] x, input logic [13:0] y, input logic [13:0] z, input logic e);
    @(posedge sys_clk);
    sample_valid <= 1'b1;
    sample_x <= x;
    sample_y <= y;
    sample_z <= z;
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    #1;
    chk({7'h00, stillness_event}, {7'h00, e});
  endtask : smp

  task automatic t_regs();
    logic [7:0] d;
    rchk(8'h23, 8'h00);
    rchk(8'h24, 8'h00);
    rchk(8'h25, 8'h00);
    rchk(8'h26, 8'h00);
    rchk(8'h27, 8'h00);
    rchk(8'h31, 8'h00);
    host.wr(8'h23, 8'hFF);
    rchk(8'h23, 8'h7F);
    host.wr(8'h24, 8'hFF);
    rchk(8'h24, 8'hFC);
    host.wr(8'h27, 8'hFF);
    rchk(8'h27, 8'h3F);
    host.wr_rd(8'h25, 8'hA5, d);
    chk(d, 8'hA5);
    host.wr(8'h26, 8'h5A);
    rchk(8'h25, 8'hA5);
    rchk(8'h26, 8'h5A);
    // Clock enable low must drop the write
    @(posedge sys_clk);
    clk_en <= 1'b0;
    host.wr(8'h26, 8'h33);
    clk_en <= 1'b1;
    rchk(8'h26, 8'h5A);
    host.wr(8'h40, 8'hFF);
    rchk(8'h40, 8'h00);
  endtask : t_regs

  // Threshold 0x101 and count 256; a boundary magnitude restarts the run
  task automatic t_count();
    host.wr(8'h23, 8'h04);
    host.wr(8'h24, 8'h04);
    host.wr(8'h25, 8'h01);
    host.wr(8'h26, 8'h00);
    host.wr(8'h31, 8'h02);
    host.wr(8'h27, 8'h04);
    for (int i = 1; i <= 255; i++) smp(14'h0100, 14'h0000, 14'h0000, 1'b0);
    smp(14'h0000, 14'h3EFF, 14'h0000, 1'b0);
    for (int i = 1; i <= 256; i++) smp(14'h0000, 14'h0000, 14'h3F00, i == 256);
    chk({7'h00, irq}, 8'h01);
    host.wr(8'h31, 8'h00);
    #1;
    chk({7'h00, irq}, 8'h00);
    host.wr(8'h31, 8'h02);
    #1;
    chk({7'h00, irq}, 8'h01);
    host.wr(8'h30, 8'h02);
    #1;
    chk({7'h00, irq}, 8'h00);
    rchk(8'h30, 8'h00);
  endtask : t_count

  task automatic t_seq();
    for (int s = 0; s < 4; s++) begin
      host.wr(8'h27, {2'b00, 2'(s), 4'b0101});
      #1;
      chk({6'h00, motion_armed, stillness_armed}, {6'h00, ~s[0], 1'b1});
      chk({7'h00, aux_motion_armed}, {7'h00, ~s[0]});
      @(posedge sys_clk);
      aux_motion_event <= 1'b1;
      @(posedge sys_clk);
      aux_motion_event <= 1'b0;
      rchk(8'h30, {5'h00, ~s[0], 2'b00});
      host.wr(8'h27, {2'b00, 2'(s), 4'b0001});
      #1;
      chk({6'h00, motion_armed, stillness_armed}, 8'h02);
    end
  endtask : t_seq

  // Alternation; only the looped code acknowledges the other event itself
  task automatic t_alt(input logic [1:0] s);
    host.wr(8'h25, 8'h00);
    host.wr(8'h26, 8'h01);
    host.wr(8'h31, 8'h03);
    host.wr(8'h27, {2'b00, s, 4'b0101});
    rchk(8'h30, 8'h00);
    smp(14'h0000, 14'h0000, 14'h0000, 1'b1);
    chk({6'h00, motion_armed, stillness_armed}, 8'h02);
    @(posedge sys_clk);
    motion_event <= 1'b1;
    @(posedge sys_clk);
    motion_event <= 1'b0;
    #1;
    chk({6'h00, motion_armed, stillness_armed}, 8'h01);
    chk({7'h00, irq}, 8'h01);
    rchk(8'h30, (s == 2'b11) ? 8'h01 : 8'h03);
    chk({7'h00, irq}, 8'h00);
    rchk(8'h30, 8'h00);
  endtask : t_alt

  initial begin
    n_mismatch = 0;
    num_checks = 0;
    rst = 1'b1;
    clk_en = 1'b1;
    sample_valid = 1'b0;
    sample_x = 14'h0000;
    sample_y = 14'h0000;
    sample_z = 14'h0000;
    motion_event = 1'b0;
    aux_motion_event = 1'b0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_count();
    t_seq();
    t_alt(2'b01);
    t_alt(2'b11);
    print_verdict();
  end

  // The full sequence needs about 1,200 cycles
  initial begin
    repeat (10000) @(posedge sys_clk);
    n_mismatch++;
    print_verdict();
  end
endmodule : tb
